// [inc/rro_defines.svh]
`ifndef RRO_DEFINES_SVH
`define RRO_DEFINES_SVH
// ----------------------------------------------------------------
// widths, field positions and cycle counts
// ----------------------------------------------------------------
`define RRO_DATA_W 8
`define RRO_PC_W 15
`define RRO_INT_EN_BIT 7
`define RRO_RET_CYCLES 2
`define RRO_ROT_CYCLES 1
`define RRO_ICTL_RST 8'h00
`define RRO_W_RST 8'h00
`define RRO_PC_RST 15'h0000
`endif

// [inc/rro_pkg.sv]
package rro_pkg;
    // instruction selector seen by this block
    typedef enum logic [2:0] {
        RRO_OP_NONE,
        RRO_OP_RETURN_FROM_INTERRUPT,
        RRO_OP_RETURN_WITH_LITERAL,
        RRO_OP_RETURN,
        RRO_OP_ROTATE_LEFT_CARRY
    } rro_op_t;

    // decoded instruction issued by the core
    typedef struct packed {
        rro_op_t op;
        logic [7:0] literal;
        logic dest_file;
        logic [7:0] file_data;
    } rro_instr_t;

    // register file write-back request
    typedef struct packed {
        logic wr_en;
        logic [7:0] data;
    } rro_fwr_t;
endpackage

// [rtl/rro_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rro_defines.svh"
module rro_core
    import rro_pkg::*;
#(
    parameter int DATA_W = `RRO_DATA_W,
    parameter int PC_W = `RRO_PC_W
) (
    input wire logic clk_i, // 20 MHz core clock
    input wire logic resetn_i, // async reset, active low
    input wire logic cyc_en_i, // instruction cycle enable pulse
    input wire logic issue_i, // new instruction offered
    input wire rro_pkg::rro_instr_t instr_i, // decoded instruction
    input wire logic [PC_W-1:0] top_of_stack_i, // stack top value
    input wire logic carry_i, // current carry flag
    input wire logic zero_i, // current zero flag
    input wire logic digit_carry_i, // current digit carry flag
    output logic ready_o, // can take an instruction
    output logic stack_pop_o, // pop request, one pulse
    output logic [PC_W-1:0] pc_o, // program counter
    output logic pc_load_o, // pc reloaded, one pulse
    output logic [DATA_W-1:0] w_o, // working register
    output logic [DATA_W-1:0] interrupt_control_reg_o, // control reg
    output logic carry_o, // new carry flag
    output logic zero_o, // zero flag, passed through
    output logic digit_carry_o, // digit carry flag, passed through
    output logic status_wr_o, // flags written, one pulse
    output var rro_pkg::rro_fwr_t file_wr_o // file register write-back
);
    import rro_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {RRO_IDLE, RRO_SECOND} rro_state_t;

    rro_state_t state_reg, state_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [DATA_W-1:0] w_reg, w_next;
    logic [DATA_W-1:0] ictl_reg, ictl_next;
    logic carry_reg, carry_next;
    logic pop_reg, pop_next;
    logic pcl_reg, pcl_next;
    logic stw_reg, stw_next;
    rro_fwr_t fwr_reg, fwr_next;

    // rotate one bit left through carry; returns {carry_out, result}
    function automatic logic [DATA_W:0] rot_left(input logic [DATA_W-1:0] v,
                                                input logic c);
        rot_left = {v, c};
    endfunction

    logic take;
    logic [DATA_W:0] rot;

    assign take = cyc_en_i && issue_i && (state_reg == RRO_IDLE);
    assign rot = rot_left(instr_i.file_data, carry_i);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        w_next = w_reg;
        ictl_next = ictl_reg;
        carry_next = carry_reg;
        pop_next = 1'b0;
        pcl_next = 1'b0;
        stw_next = 1'b0;
        fwr_next = '0;
        fwr_next.data = fwr_reg.data;
        case (state_reg)
            RRO_IDLE: begin
                if (take) begin
                    case (instr_i.op)
                        RRO_OP_RETURN_FROM_INTERRUPT: begin
                            pc_next = top_of_stack_i;
                            pop_next = 1'b1;
                            pcl_next = 1'b1;
                            ictl_next[`RRO_INT_EN_BIT] = 1'b1;
                            state_next = RRO_SECOND;
                        end
                        RRO_OP_RETURN_WITH_LITERAL: begin
                            w_next = instr_i.literal;
                            pc_next = top_of_stack_i;
                            pop_next = 1'b1;
                            pcl_next = 1'b1;
                            state_next = RRO_SECOND;
                        end
                        RRO_OP_RETURN: begin
                            pc_next = top_of_stack_i;
                            pop_next = 1'b1;
                            pcl_next = 1'b1;
                            state_next = RRO_SECOND;
                        end
                        RRO_OP_ROTATE_LEFT_CARRY: begin
                            carry_next = rot[DATA_W];
                            stw_next = 1'b1;
                            if (instr_i.dest_file) begin
                                fwr_next.wr_en = 1'b1;
                                fwr_next.data = rot[DATA_W-1:0];
                            end else begin
                                w_next = rot[DATA_W-1:0];
                            end
                        end
                        default: begin
                            state_next = RRO_IDLE;
                        end
                    endcase
                end
            end
            RRO_SECOND: begin
                // second cycle of a return is the pipeline flush
                if (cyc_en_i) begin
                    state_next = RRO_IDLE;
                end
            end
            default: begin
                state_next = RRO_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= RRO_IDLE;
            pc_reg <= `RRO_PC_RST;
            w_reg <= `RRO_W_RST;
            ictl_reg <= `RRO_ICTL_RST;
            carry_reg <= 1'b0;
            pop_reg <= 1'b0;
            pcl_reg <= 1'b0;
            stw_reg <= 1'b0;
            fwr_reg <= '0;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            w_reg <= w_next;
            ictl_reg <= ictl_next;
            carry_reg <= carry_next;
            pop_reg <= pop_next;
            pcl_reg <= pcl_next;
            stw_reg <= stw_next;
            fwr_reg <= fwr_next;
        end
    end

    // outputs; zero and digit carry always pass through unchanged
    assign ready_o = (state_reg == RRO_IDLE);
    assign stack_pop_o = pop_reg;
    assign pc_o = pc_reg;
    assign pc_load_o = pcl_reg;
    assign w_o = w_reg;
    assign interrupt_control_reg_o = ictl_reg;
    assign carry_o = carry_reg;
    assign zero_o = zero_i;
    assign digit_carry_o = digit_carry_i;
    assign status_wr_o = stw_reg;
    assign file_wr_o = fwr_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // all checks run on the core clock and sleep through reset
    default clocking rro_cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_rfi_pc_load: assert property (
        take && instr_i.op == RRO_OP_RETURN_FROM_INTERRUPT |=>
        pc_reg == $past(top_of_stack_i) && pop_reg)
        else $error("return from interrupt did not load pc");
    a_rfi_enable_set: assert property (
        take && instr_i.op == RRO_OP_RETURN_FROM_INTERRUPT |=>
        ictl_reg[`RRO_INT_EN_BIT])
        else $error("global interrupt enable not set");
    a_rfi_two_cyc: assert property (
        take && instr_i.op == RRO_OP_RETURN_FROM_INTERRUPT |=>
        !ready_o)
        else $error("return from interrupt not two cycles");
    a_rwl_w_load: assert property (
        take && instr_i.op == RRO_OP_RETURN_WITH_LITERAL |=>
        w_reg == $past(instr_i.literal))
        else $error("literal not placed in working register");
    a_rwl_pc_load: assert property (
        take && instr_i.op == RRO_OP_RETURN_WITH_LITERAL |=>
        pc_reg == $past(top_of_stack_i) && !ready_o)
        else $error("return with literal pc or timing wrong");
    a_ret_keep_w: assert property (
        take && instr_i.op == RRO_OP_RETURN |=>
        w_reg == $past(w_reg) && carry_reg == $past(carry_reg) &&
        pc_reg == $past(top_of_stack_i))
        else $error("plain return disturbed working state");
    a_ret_two_cyc: assert property (
        take && instr_i.op == RRO_OP_RETURN |=> !ready_o)
        else $error("plain return not two cycles");
    a_rot_carry: assert property (
        take && instr_i.op == RRO_OP_ROTATE_LEFT_CARRY |=>
        carry_reg == $past(instr_i.file_data[DATA_W-1]))
        else $error("rotate carry out wrong");
    a_rot_dest: assert property (
        take && instr_i.op == RRO_OP_ROTATE_LEFT_CARRY &&
        !instr_i.dest_file |=> !file_wr_o.wr_en &&
        w_reg == {$past(instr_i.file_data[DATA_W-2:0]), $past(carry_i)})
        else $error("rotate to working register wrong");
    a_rot_file_wr: assert property (
        take && instr_i.op == RRO_OP_ROTATE_LEFT_CARRY &&
        instr_i.dest_file |=> file_wr_o.wr_en &&
        w_reg == $past(w_reg) && file_wr_o.data[0] == $past(carry_i) &&
        file_wr_o.data[DATA_W-1:1] == $past(instr_i.file_data[DATA_W-2:0]))
        else $error("rotate to file register wrong");
    a_rot_single: assert property (
        take && instr_i.op == RRO_OP_ROTATE_LEFT_CARRY |=> ready_o)
        else $error("rotate not single cycle");
endmodule
`default_nettype wire

// [verification/return_and_rotate_ops_test.sv]
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_ops_test;
    import rro_pkg::*;
    logic clk_i, resetn_i, cyc_en_i, issue_i;
    logic carry_i, zero_i, digit_carry_i;
    rro_instr_t instr_i;
    logic [14:0] top_of_stack_i, pc_o, exp_pc;
    logic ready_o, stack_pop_o, pc_load_o, carry_o, zero_o;
    logic digit_carry_o, status_wr_o, exp_c;
    logic [7:0] w_o, ctrl_reg, exp_w, exp_ctrl;
    rro_fwr_t file_wr_o;
    int err_total, tests_run, cycles, k;

    rro_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_en_i(cyc_en_i),
        .issue_i(issue_i), .instr_i(instr_i),
        .top_of_stack_i(top_of_stack_i), .carry_i(carry_i), .zero_i(zero_i),
        .digit_carry_i(digit_carry_i), .ready_o(ready_o),
        .stack_pop_o(stack_pop_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
        .w_o(w_o), .interrupt_control_reg_o(ctrl_reg), .carry_o(carry_o),
        .zero_o(zero_o), .digit_carry_o(digit_carry_o),
        .status_wr_o(status_wr_o), .file_wr_o(file_wr_o));

    // ----------------------------------------------------------------
    // clock, timeout and shared helpers
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // cut a hang short, well past the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    // new carry in the top bit, rotated byte below it
    function automatic logic [8:0] rotl(input logic [7:0] v, input logic c);
        return {v, c};
    endfunction

    // ----------------------------------------------------------------
    // instruction drivers with their checks
    // ----------------------------------------------------------------
    // return op; a rotate offered in its second cycle must be ignored
    task automatic do_ret(input rro_op_t op, input logic [7:0] lit,
                          input logic [14:0] top_of_stack);
        instr_i = '{op, lit, 1'b0, 8'h00};
        top_of_stack_i = top_of_stack;
        issue_i = 1'b1;
        @(negedge clk_i);
        exp_pc = top_of_stack;
        if (op == RRO_OP_RETURN_WITH_LITERAL) exp_w = lit;
        if (op == RRO_OP_RETURN_FROM_INTERRUPT) exp_ctrl[7] = 1'b1;
        chk(pc_o === exp_pc, "pc not reloaded");
        chk(pc_load_o === 1'b1, "no pc load");
        chk(stack_pop_o === 1'b1, "no stack pop");
        chk(ctrl_reg === exp_ctrl, "control reg wrong");
        chk(w_o === exp_w, "working reg wrong");
        chk(carry_o === exp_c, "carry hit");
        chk(status_wr_o === 1'b0, "status hit");
        chk(ready_o === 1'b0, "ready in second cycle");
        instr_i = '{RRO_OP_ROTATE_LEFT_CARRY, 8'h00, 1'b1, 8'h5a};
        @(negedge clk_i);
        chk(ready_o === 1'b1, "not two cycles");
        chk(pc_load_o === 1'b0, "pc load held");
        chk(stack_pop_o === 1'b0, "pop held");
        chk(file_wr_o.wr_en === 1'b0, "busy take");
    endtask

    // rotate op; issue left high so rotates can run back to back
    task automatic do_rot(input logic d, input logic [7:0] v, input logic c);
        logic [8:0] r;
        r = rotl(v, c);
        instr_i = '{RRO_OP_ROTATE_LEFT_CARRY, 8'h00, d, v};
        carry_i = c;
        zero_i = 1'($urandom);
        digit_carry_i = 1'($urandom);
        issue_i = 1'b1;
        @(negedge clk_i);
        exp_c = r[8];
        if (!d) exp_w = r[7:0];
        chk(w_o === exp_w, "rotate result");
        chk(carry_o === exp_c, "rotate carry");
        chk(file_wr_o.wr_en === d, "write-back select");
        chk(!d || file_wr_o.data === r[7:0], "wb data");
        chk(status_wr_o === 1'b1, "status pulse");
        chk(ready_o === 1'b1, "rotate timing");
        chk(zero_o === zero_i, "zero flag");
        chk(digit_carry_o === digit_carry_i, "digit carry");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h9392_f1e9));
        {resetn_i, issue_i, carry_i, zero_i, digit_carry_i} = 5'h00;
        cyc_en_i = 1'b1;
        instr_i = '{RRO_OP_NONE, 8'h00, 1'b0, 8'h00};
        top_of_stack_i = 15'h0000;
        {exp_w, exp_ctrl, exp_pc, exp_c} = '0;
        repeat (10) @(negedge clk_i);
        chk(pc_o === 15'h0000 && w_o === 8'h00 && ready_o === 1'b1, "reset");
        chk(ctrl_reg === 8'h00 && carry_o === 1'b0, "reset flags");
        resetn_i = 1'b1;
        do_rot(1'b0, 8'he6, 1'b0);
        do_rot(1'b1, 8'h80, 1'b1);
        do_rot(1'b1, 8'h01, 1'b0);
        do_ret(RRO_OP_RETURN, 8'h00, 15'h7fff);
        do_ret(RRO_OP_RETURN_WITH_LITERAL, 8'hff, 15'h0001);
        do_ret(RRO_OP_RETURN_WITH_LITERAL, 8'h00, 15'h4000);
        do_ret(RRO_OP_RETURN_FROM_INTERRUPT, 8'h00, 15'h2a55);
        // an idle op and a disabled cycle must leave everything alone
        instr_i = '{RRO_OP_NONE, 8'h00, 1'b1, 8'hff};
        issue_i = 1'b1;
        @(negedge clk_i);
        instr_i = '{RRO_OP_ROTATE_LEFT_CARRY, 8'h00, 1'b0, 8'hff};
        cyc_en_i = 1'b0;
        @(negedge clk_i);
        chk(w_o === exp_w && status_wr_o === 1'b0, "idle cycle acted");
        chk(pc_load_o === 1'b0 && file_wr_o.wr_en === 1'b0, "idle write");
        cyc_en_i = 1'b1;
        for (int i = 0; i < 40; i++) begin
            k = $urandom_range(3, 0);
            if (k < 2) begin
                do_rot(k[0], 8'($urandom), 1'($urandom));
            end else begin
                do_ret(k == 2 ? RRO_OP_RETURN_WITH_LITERAL : RRO_OP_RETURN,
                    8'($urandom), 15'($urandom));
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
